/* inc/ppr_defines.vh */
// Register offsets, field positions, reset values and widths for the peripheral pin remap block.
`ifndef PPR_DEFINES_VH
`define PPR_DEFINES_VH
`define PPR_ADDR_W 4
`define PPR_OFS_SEL4 4'h0
`define PPR_OFS_SEL5 4'h1
`define PPR_OFS_DED_OUT_EN 4'h2
`define PPR_OFS_ANALOG_SEL 4'h3
`define PPR_OFS_LATCH 4'h4
`define PPR_OFS_PIN_LEVEL 4'h5
`define PPR_OFS_PIN_STATUS 4'h6
`define PPR_FUNC_W 6
`define PPR_FLD_LO_LSB 0
`define PPR_FLD_HI_LSB 8
`define PPR_SEL_RESET 6'h00
`define PPR_FUNC_NONE 6'h00
`define PPR_ANALOG_RESET 4'hF
`define PPR_CTRL_RESET 4'h0
`define PPR_NUM_PINS 4
`endif

/* hdl/ppr_pin_slice.v */
// One pin's output and input arbitration between dedicated, analog and remapped functions.
`include "ppr_defines.vh"

module ppr_pin_slice #(
  parameter NUM_FUNCS = 64
)
(
  input wire [5:0] func_sel,
  input wire [NUM_FUNCS-1:0] periph_out,
  input wire ded_en,
  input wire ded_out,
  input wire analog_en,
  input wire latch_val,
  input wire pin_in,
  output reg pin_out,
  output reg pin_oe,
  output wire pin_dig_in,
  output wire remap_active
)
;
  assign remap_active = (func_sel != `PPR_FUNC_NONE);

  // Exactly one source is chosen, so the pin never has two drivers.
  always @*
  begin
    pin_oe = 1'b1;
    if (ded_en)
    begin
      pin_out = ded_out;
    end
    else if (remap_active)
    begin
      pin_out = periph_out[func_sel];
    end
    else
    begin
      pin_out = latch_val;
    end
  end

  // Analog mode blocks every digital input path but leaves the driver alone.
  assign pin_dig_in = analog_en ? 1'b0 : pin_in;
endmodule

/* hdl/peripheral_pin_remap.v */
// Peripheral pin remap: output-select registers and per-pin routing for four remappable pins.
`include "ppr_defines.vh"

//Contract
// - One output function at most drives any pin at a time.
// - A remappable output function may be selected on several pins together.
// - An enabled dedicated output overrides any remappable output on its pin.
// - Remapped inputs still read a pin used by a dedicated digital function.
// - Analog enable on a pin disables all digital input paths from it.
// - With analog enabled, one digital output may still drive the pin.
// - Any number of remapped inputs may take the same pin simultaneously.
// - Each select register holds fields at bits 13:8 and 5:0.
// - Bits 15:14 and 7:6 ignore writes and read zero.
// - Pins 42,43 and 54,55 pair in registers, lower pin in low field.
// - Analog pins read zero through pin level and latch views.
// - Leftmost, highest-priority function wins; lower ones stay inactive. Under a dedicated output, remap_active still reads 1 for a selected remap.
module peripheral_pin_remap #(
  parameter NUM_FUNCS = 64,
  parameter NUM_PINS = 4
)
(
  input wire clk,
  input wire rst,
  input wire [3:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  input wire [NUM_FUNCS-1:0] periph_out,
  input wire [NUM_PINS-1:0] ded_out_en,
  input wire [NUM_PINS-1:0] ded_out,
  output wire [NUM_PINS-1:0] pin_out,
  output wire [NUM_PINS-1:0] pin_oe,
  input wire [NUM_PINS-1:0] pin_in,
  output wire [NUM_PINS-1:0] pin_dig_in,
  output wire [NUM_PINS-1:0] remap_active
)
;
  // Pin index 0..3 stands for remappable pins 42, 43, 54, 55.
  reg [5:0] sel_ff [0:NUM_PINS-1];
  reg [5:0] nxt_sel [0:NUM_PINS-1];
  reg [NUM_PINS-1:0] analog_ff;
  reg [NUM_PINS-1:0] latch_ff;
  reg [NUM_PINS-1:0] sw_ded_en_ff;
  reg [15:0] nxt_rdata;
  wire [NUM_PINS-1:0] ded_en;
  wire [NUM_PINS-1:0] pin_view;
  wire [NUM_PINS-1:0] latch_view;
  integer i;

  assign ded_en = ded_out_en | sw_ded_en_ff;

  always @*
  begin
    for (i = 0; i < NUM_PINS; i = i + 1)
    begin
      nxt_sel[i] = sel_ff[i];
    end
    if (reg_wr && reg_addr == `PPR_OFS_SEL4)
    begin
      nxt_sel[0] = reg_wdata[`PPR_FLD_LO_LSB +: 6];
      nxt_sel[1] = reg_wdata[`PPR_FLD_HI_LSB +: 6];
    end
    if (reg_wr && reg_addr == `PPR_OFS_SEL5)
    begin
      nxt_sel[2] = reg_wdata[`PPR_FLD_LO_LSB +: 6];
      nxt_sel[3] = reg_wdata[`PPR_FLD_HI_LSB +: 6];
    end
  end

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      for (i = 0; i < NUM_PINS; i = i + 1)
      begin
        sel_ff[i] <= `PPR_SEL_RESET;
      end
      analog_ff <= `PPR_ANALOG_RESET;
      latch_ff <= `PPR_CTRL_RESET;
      sw_ded_en_ff <= `PPR_CTRL_RESET;
    end
    else
    begin
      for (i = 0; i < NUM_PINS; i = i + 1)
      begin
        sel_ff[i] <= nxt_sel[i];
      end
      if (reg_wr && reg_addr == `PPR_OFS_ANALOG_SEL)
      begin
        analog_ff <= reg_wdata[3:0];
      end
      if (reg_wr && reg_addr == `PPR_OFS_LATCH)
      begin
        latch_ff <= reg_wdata[3:0];
      end
      if (reg_wr && reg_addr == `PPR_OFS_DED_OUT_EN)
      begin
        sw_ded_en_ff <= reg_wdata[3:0];
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_PINS; g = g + 1)
    begin : gen_pin
      ppr_pin_slice #(
        .NUM_FUNCS(NUM_FUNCS)
      )
      u_slice
      (
        .func_sel(sel_ff[g]),
        .periph_out(periph_out),
        .ded_en(ded_en[g]),
        .ded_out(ded_out[g]),
        .analog_en(analog_ff[g]),
        .latch_val(latch_ff[g]),
        .pin_in(pin_in[g]),
        .pin_out(pin_out[g]),
        .pin_oe(pin_oe[g]),
        .pin_dig_in(pin_dig_in[g]),
        .remap_active(remap_active[g])
      );
    end
  endgenerate

  // Analog pins must not leak digital levels into software reads.
  assign pin_view = pin_in & ~analog_ff;
  assign latch_view = latch_ff & ~analog_ff;

  always @*
  begin
    nxt_rdata = 16'h0000;
    case (reg_addr)
      `PPR_OFS_SEL4: nxt_rdata = {2'b00, sel_ff[1], 2'b00, sel_ff[0]};
      `PPR_OFS_SEL5: nxt_rdata = {2'b00, sel_ff[3], 2'b00, sel_ff[2]};
      `PPR_OFS_DED_OUT_EN: nxt_rdata = {12'h000, sw_ded_en_ff};
      `PPR_OFS_ANALOG_SEL: nxt_rdata = {12'h000, analog_ff};
      `PPR_OFS_LATCH: nxt_rdata = {12'h000, latch_view};
      `PPR_OFS_PIN_LEVEL: nxt_rdata = {12'h000, pin_view};
      `PPR_OFS_PIN_STATUS: nxt_rdata = {8'h00, ded_en, remap_active};
      default: nxt_rdata = 16'h0000;
    endcase
  end

  // Read data stand only in the cycle after the read strobe.
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      reg_rdata <= 16'h0000;
    end
    else if (reg_rd)
    begin
      reg_rdata <= nxt_rdata;
    end
    else
    begin
      reg_rdata <= 16'h0000;
    end
  end
endmodule

/* tb/ppr_props.sv */
// Checker for the pin remap register port and pin routing.
module ppr_props #(
  parameter NUM_PINS = 4
)
(
  input wire clk,
  input wire rst,
  input wire [3:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [15:0] reg_rdata,
  input wire [NUM_PINS-1:0] ded_out_en,
  input wire [NUM_PINS-1:0] ded_out,
  input wire [NUM_PINS-1:0] pin_out,
  input wire [NUM_PINS-1:0] pin_in,
  input wire [NUM_PINS-1:0] pin_dig_in,
  input wire [NUM_PINS-1:0] remap_active
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence s_sel_wr;
    reg_wr && reg_addr < 4'h2;
  endsequence
  sequence s_wr_rd;
    s_sel_wr ##1 reg_rd && reg_addr == $past(reg_addr);
  endsequence
  rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0)
    else $error("read data not idle");
  rd_back_a: assert property (s_wr_rd |=> reg_rdata == ($past(reg_wdata, 2) & 16'h3F3F))
    else $error("select readback wrong");
  rd_unmap_a: assert property ($past(reg_rd && reg_addr > 4'h6) |-> reg_rdata == 16'h0)
    else $error("unmapped read not zero");
  sel_lo_a: assert property ($past(reg_wr && reg_addr == 4'h0) |->
    remap_active[1:0] == {|$past(reg_wdata[13:8]), |$past(reg_wdata[5:0])}) else $error("low select wrong");
  sel_hi_a: assert property ($past(reg_wr && reg_addr == 4'h1) |->
    remap_active[3:2] == {|$past(reg_wdata[13:8]), |$past(reg_wdata[5:0])}) else $error("high select wrong");
  ded_prio_a: assert property ((pin_out & ded_out_en) == (ded_out & ded_out_en))
    else $error("dedicated output lost");
  dig_gate_a: assert property ((pin_dig_in & ~pin_in) == '0)
    else $error("digital input not gated");
  sel_reset_a: assert property (@(posedge clk) disable iff (1'b0) rst |-> remap_active == '0)
    else $error("selects not cleared");
endmodule

bind peripheral_pin_remap ppr_props #(.NUM_PINS(NUM_PINS)) u_props (.clk(clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ded_out_en(ded_out_en),
  .ded_out(ded_out), .pin_out(pin_out), .pin_in(pin_in), .pin_dig_in(pin_dig_in), .remap_active(remap_active));

/* tb/ppr_pads.sv */
// Pin pads: a driven pin reads back its drive, a released one the inverse so stale levels show.
module ppr_pads (
  input wire [3:0] pin_out,
  input wire [3:0] pin_oe,
  output wire [3:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  assign pin_in = (pin_out & pin_oe) | (~pin_out & ~pin_oe);
endmodule

/* tb/tb.sv */
// Bench for the pin remap block.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = '0, rst = '0, reg_wr = '0, reg_rd = '0, rd_d = '0;
  logic [3:0] reg_addr = '0, ded_out_en = '0, ded_out = '0, ex;
  logic [15:0] reg_wdata = '0, s = 16'h0026;
  logic [63:0] periph_out = '0;
  logic [15:0] q[$];
  wire [15:0] reg_rdata;
  wire [3:0] pin_out, pin_oe, pin_in, pin_dig_in, remap_active;
  int fails = 0, checked = 0, cyc = 0;
  always #5 clk = ~clk;
  peripheral_pin_remap dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .periph_out(periph_out), .ded_out_en(ded_out_en), .ded_out(ded_out),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in), .pin_dig_in(pin_dig_in), .remap_active(remap_active));
  ppr_pads pads (.pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));
  function automatic logic [15:0] lf(logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    checked++;
    if (g !== e)
    begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // Each call holds its strobe for exactly one edge; a read notes its expectation.
  task automatic op(logic w, logic r, logic [3:0] a, logic [15:0] d);
    @(posedge clk);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
    if (r) q.push_back(d);
  endtask
  task automatic test_done;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    rd_d <= reg_rd;
    if (rd_d) chk("rdata", q.pop_front(), reg_rdata);
    if (cyc == 2000)
    begin
      fails++;
      test_done;
    end
  end
  initial
  begin
    rst <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    op(0, 1, 4'h0, 16'h0000);
    op(0, 1, 4'h1, 16'h0000);
    op(0, 1, 4'hF, 16'h0000);
    repeat (8)
    begin
      s = lf(s);
      op(1, 0, 4'h0, s);
      op(0, 1, 4'h0, s & 16'h3F3F);
      op(1, 0, 4'h1, ~s);
      op(0, 1, 4'h1, ~s & 16'h3F3F);
    end
    op(1, 0, 4'h3, 16'h0000);
    op(1, 0, 4'h4, 16'h000A);
    op(1, 0, 4'h0, 16'h0000);
    op(1, 0, 4'h1, 16'h0000);
    op(0, 0, 4'h0, 16'h0000);
    #1 chk("latch", 16'h000A, {12'h000, pin_out});
    chk("oe", 16'h000F, {12'h000, pin_oe});
    op(1, 0, 4'h0, 16'h0305);
    op(1, 0, 4'h1, 16'h0505);
    op(0, 0, 4'h0, 16'h0000);
    repeat (4)
    begin
      s = lf(s);
      @(posedge clk);
      periph_out <= {4{s}};
      #2 ex = {periph_out[5], periph_out[5], periph_out[3], periph_out[5]};
      chk("remap", {12'h000, ex}, {12'h000, pin_out});
    end
    @(posedge clk);
    ded_out_en <= 4'h5;
    ded_out <= s[3:0];
    #2 ex = (s[3:0] & 4'h5) | (ex & 4'hA);
    chk("ded", {12'h000, ex}, {12'h000, pin_out});
    chk("dig", {12'h000, ex}, {12'h000, pin_dig_in});
    op(1, 0, 4'h2, 16'hFFF2);
    op(0, 1, 4'h6, 16'h007F);
    ex = (ex & 4'hD) | (s[3:0] & 4'h2);
    op(1, 0, 4'h3, 16'h000F);
    op(0, 1, 4'h5, 16'h0000);
    op(0, 1, 4'h4, 16'h0000);
    op(0, 0, 4'h0, 16'h0000);
    #1 chk("gate", 16'h0000, {12'h000, pin_dig_in});
    chk("drive", {12'h000, ex}, {12'h000, pin_out});
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    op(0, 1, 4'h1, 16'h0000);
    op(0, 0, 4'h0, 16'h0000);
    repeat (3) @(posedge clk);
    test_done;
  end
endmodule
